/* File: adcdt_diag_top.sv */
// Test and diagnosis logic around the dual sigma-delta converter path.
// Function
// - Mode 7 at full power: mux from register
// - Otherwise mux from mode or power manager
// - Voltage/temperature select code maps to input pairs
// - Shunt select code maps to input pairs
// - Applied reference comes from selected source
// - Bias source enables act in every mode
// - Self-test feeds one stream to both filters
// - Low 30 threshold bits rotate, bit0 emitted
// - Threshold function unavailable during self-test
// - Pattern 20820820 yields AAAAAA or 800000
// - Raw capture: MSB half max, LSB min
// - Raw capture stops only min/max tracking
// - The three test features combine freely
// - Interface test samples modulator bits on strobe
// - Interface test only at full power
// - Pad sends 1, 0, then 4-bit value
// - Diag register bits 0..2 enable features
`timescale 1ns/1ps
`default_nettype none
`include "adcdt_cfg.svh"
module adcdt_diag_top
  import adcdt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // Converter control inputs
  input wire logic fullPower,
  input wire logic [2:0] conversionMode,
  input wire logic [2:0] modeVtSel,
  input wire logic [2:0] modeCurSel,
  input wire logic [2:0] pmuVtSel,
  input wire logic [2:0] pmuCurSel,
  input wire logic refSourceSel,
  // Multiplexer and bias outputs
  output adcdt_pair_s vtPair,
  output adcdt_pair_s curPair,
  output logic refApplied,
  output logic refSourceOut,
  output logic [7:0] biasSourceEnables,
  // Decimation filter inputs
  input wire logic sdmStrobe,
  input wire logic noiseCancelCur,
  input wire logic noiseCancelVolt,
  output logic decimInCur,
  output logic decimInVolt,
  output logic accumThreshAvail,
  // Decimation filter outputs and capture
  input wire logic decimCurValid,
  input wire logic [31:0] decimCurOut,
  input wire logic decimVoltValid,
  input wire logic [31:0] decimVoltOut,
  output adcdt_raw_s shuntCapture,
  output adcdt_raw_s voltCapture,
  output logic shuntCaptureWr,
  output logic voltCaptureWr,
  output logic minMaxTrackEn,
  // Modulator streams and test pad
  input wire logic [3:0] modulatorBits,
  output logic serialTestOut
);

  // ****************************************************************
  // Multiplexer decode
  // ****************************************************************
  function automatic adcdt_pair_s vtDecode(input logic [2:0] c);
    unique case (c)
      3'h0: vtDecode = '{ND_VDDA, ND_THERM_HI};
      3'h1: vtDecode = '{ND_THERM_LO, ND_THERM_HI};
      3'h2: vtDecode = '{ND_PTAT, ND_VREF};
      3'h3: vtDecode = '{ND_VBATP, ND_VBATN};
      3'h4: vtDecode = '{ND_VREF, ND_GND};
      3'h5: vtDecode = '{ND_VREFLP, ND_GND};
      3'h6: vtDecode = '{ND_VCM, ND_VCM};
      3'h7: vtDecode = '{ND_HIZ, ND_HIZ};
    endcase
  endfunction : vtDecode

  function automatic adcdt_pair_s curDecode(input logic [2:0] c);
    unique case (c)
      3'h0, 3'h1, 3'h2, 3'h3: curDecode = '{ND_SHUNTP, ND_SHUNTN};
      3'h4: curDecode = '{ND_MV1, ND_GND};
      3'h7: curDecode = '{ND_VCM, ND_VCM};
      default: curDecode = '{ND_HIZ, ND_HIZ};
    endcase
  endfunction : curDecode

  function automatic logic usesRef(input adcdt_pair_s p);
    usesRef = (p.pos == ND_VREF) || (p.neg == ND_VREF);
  endfunction : usesRef

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] muxSelReg, muxSelNext;
  logic [7:0] diagReg, diagNext;
  logic [7:0] biasReg, biasNext;
  logic [29:0] patternReg, patternNext;
  logic [1:0] threshTopReg, threshTopNext;
  logic [7:0] rdDataReg, rdDataNext;
  logic [31:0] threshWord;
  logic selfTestOn, rawOn, ifTestOn;

  assign selfTestOn = diagReg[`ADCDT_DIAG_SELFTEST_BIT];
  assign rawOn = diagReg[`ADCDT_DIAG_RAW_BIT];
  assign ifTestOn = diagReg[`ADCDT_DIAG_IFTEST_BIT];
  assign threshWord = {threshTopReg, patternReg};

  always_comb begin
    muxSelNext = muxSelReg;
    diagNext = diagReg;
    biasNext = biasReg;
    threshTopNext = threshTopReg;
    patternNext = patternReg;
    rdDataNext = rdDataReg;
    // Pattern rotates right on each sample strobe during self-test.
    if (selfTestOn && sdmStrobe) begin
      patternNext = {patternReg[0], patternReg[29:1]};
    end
    if (regWrEn) begin
      unique case (regAddr)
        `ADCDT_MUXSEL_ADDR: muxSelNext = regWrData;
        `ADCDT_DIAG_ADDR: diagNext = regWrData;
        `ADCDT_BIAS_ADDR: biasNext = regWrData;
        `ADCDT_THRESH0_ADDR: patternNext[7:0] = regWrData;
        `ADCDT_THRESH1_ADDR: patternNext[15:8] = regWrData;
        `ADCDT_THRESH2_ADDR: patternNext[23:16] = regWrData;
        `ADCDT_THRESH3_ADDR: begin
          patternNext[29:24] = regWrData[5:0];
          threshTopNext = regWrData[7:6];
        end
        default: ;
      endcase
    end
    if (regRdEn) begin
      unique case (regAddr)
        `ADCDT_MUXSEL_ADDR: rdDataNext = muxSelReg;
        `ADCDT_DIAG_ADDR: rdDataNext = diagReg;
        `ADCDT_BIAS_ADDR: rdDataNext = biasReg;
        `ADCDT_THRESH0_ADDR: rdDataNext = threshWord[7:0];
        `ADCDT_THRESH1_ADDR: rdDataNext = threshWord[15:8];
        `ADCDT_THRESH2_ADDR: rdDataNext = threshWord[23:16];
        `ADCDT_THRESH3_ADDR: rdDataNext = threshWord[31:24];
        default: rdDataNext = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      muxSelReg <= `ADCDT_MUXSEL_RESET;
      diagReg <= `ADCDT_DIAG_RESET;
      biasReg <= `ADCDT_BIAS_RESET;
      patternReg <= 30'(`ADCDT_THRESH_RESET);
      threshTopReg <= 2'h0;
      rdDataReg <= 8'h00;
    end else begin
      muxSelReg <= muxSelNext;
      diagReg <= diagNext;
      biasReg <= biasNext;
      patternReg <= patternNext;
      threshTopReg <= threshTopNext;
      rdDataReg <= rdDataNext;
    end
  end

  assign regRdData = rdDataReg;
  assign biasSourceEnables = biasReg;
  // Bit 0 leaves the pattern as the test stream.
  assign accumThreshAvail = !selfTestOn;

  // ****************************************************************
  // Multiplexer steering
  // ****************************************************************
  adcdt_pair_s vtPairReg, vtPairNext, curPairReg, curPairNext;
  logic refAppliedReg, refAppliedNext, refSrcReg, refSrcNext;
  logic directMux;

  assign directMux = fullPower && conversionMode == `ADCDT_DIRECT_MODE;

  always_comb begin
    if (directMux) begin
      vtPairNext = vtDecode(muxSelReg[`ADCDT_VOLT_TEMP_INPUT_SELECT_MSB:`ADCDT_VOLT_TEMP_INPUT_SELECT_LSB]);
      curPairNext = curDecode(muxSelReg[`ADCDT_SHUNT_INPUT_SELECT_MSB:`ADCDT_SHUNT_INPUT_SELECT_LSB]);
    end else if (fullPower) begin
      vtPairNext = vtDecode(modeVtSel);
      curPairNext = curDecode(modeCurSel);
    end else begin
      vtPairNext = vtDecode(pmuVtSel);
      curPairNext = curDecode(pmuCurSel);
    end
    refAppliedNext = usesRef(vtPairNext) || usesRef(curPairNext);
    refSrcNext = refAppliedNext ? refSourceSel : refSrcReg;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vtPairReg <= '{ND_VDDA, ND_THERM_HI};
      curPairReg <= '{ND_SHUNTP, ND_SHUNTN};
      refAppliedReg <= 1'b0;
      refSrcReg <= 1'b0;
    end else begin
      vtPairReg <= vtPairNext;
      curPairReg <= curPairNext;
      refAppliedReg <= refAppliedNext;
      refSrcReg <= refSrcNext;
    end
  end

  assign vtPair = vtPairReg;
  assign curPair = curPairReg;
  assign refApplied = refAppliedReg;
  assign refSourceOut = refSrcReg;

  // ****************************************************************
  // Filter inputs and raw capture
  // ****************************************************************
  adcdt_raw_s shuntCapReg, shuntCapNext, voltCapReg, voltCapNext;
  logic shuntWrReg, shuntWrNext, voltWrReg, voltWrNext;

  // In self-test both filters take the same stream; features are independent.
  assign decimInCur = selfTestOn ? patternReg[0] : noiseCancelCur;
  assign decimInVolt = selfTestOn ? patternReg[0] : noiseCancelVolt;
  assign minMaxTrackEn = !rawOn;

  always_comb begin
    shuntWrNext = rawOn && decimCurValid;
    voltWrNext = rawOn && decimVoltValid;
    shuntCapNext = shuntWrNext ? decimCurOut : shuntCapReg;
    voltCapNext = voltWrNext ? decimVoltOut : voltCapReg;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shuntCapReg <= '0;
      voltCapReg <= '0;
      shuntWrReg <= 1'b0;
      voltWrReg <= 1'b0;
    end else begin
      shuntCapReg <= shuntCapNext;
      voltCapReg <= voltCapNext;
      shuntWrReg <= shuntWrNext;
      voltWrReg <= voltWrNext;
    end
  end

  assign shuntCapture = shuntCapReg;
  assign voltCapture = voltCapReg;
  assign shuntCaptureWr = shuntWrReg;
  assign voltCaptureWr = voltWrReg;

  // ****************************************************************
  // Interface test
  // ****************************************************************
  logic [3:0] modMetaReg, modSyncReg;
  logic ifTestRun;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      modMetaReg <= 4'h0;
      modSyncReg <= 4'h0;
    end else begin
      modMetaReg <= modulatorBits;
      modSyncReg <= modMetaReg;
    end
  end

  assign ifTestRun = ifTestOn && fullPower;

  adcdt_sto_shifter u_shifter (
    .clk(clk),
    .arst_n(arst_n),
    .enable(ifTestRun),
    .sampleStrobe(sdmStrobe),
    .sampleBits(modSyncReg),
    .stoBit(serialTestOut)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  direct_mux_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    directMux |=> vtPair == vtDecode($past(muxSelReg[2:0]))
      && curPair == curDecode($past(muxSelReg[5:3])))
    else $error("Mux not driven from select register.");

  mode_mux_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (fullPower && !directMux) |=> vtPair == vtDecode($past(modeVtSel)))
    else $error("Mux not steered by conversion mode.");

  pmu_mux_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    !fullPower |=> curPair == curDecode($past(pmuCurSel)))
    else $error("Mux not steered by power manager.");

  ref_source_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    refApplied |-> refSourceOut == $past(refSourceSel))
    else $error("Reference source does not follow select.");

  bias_pass_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (regWrEn && regAddr == `ADCDT_BIAS_ADDR)
      |=> biasSourceEnables == $past(regWrData))
    else $error("Bias enables not taken in this mode.");

  same_stream_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    selfTestOn |-> decimInCur == decimInVolt
      && decimInCur == patternReg[0] && !accumThreshAvail)
    else $error("Filters not fed from the test pattern.");

  pattern_rot_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (selfTestOn && sdmStrobe && !regWrEn)
      |=> patternReg == {$past(patternReg[0]), $past(patternReg[29:1])})
    else $error("Pattern did not rotate right by one.");

  raw_store_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (rawOn && decimCurValid) |-> !minMaxTrackEn ##1 (shuntCaptureWr
      && shuntCapture.hi == $past(decimCurOut[31:16])
      && shuntCapture.lo == $past(decimCurOut[15:0])))
    else $error("Raw filter word not split into max and min.");

  iftest_power_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (!fullPower && u_shifter.stateReg == ST_IDLE) |=> !serialTestOut)
    else $error("Interface test ran outside full power.");

endmodule : adcdt_diag_top
`default_nettype wire

/* File: adcdt_cfg.svh */
// Offsets, field positions, reset values and counts of the ADC test logic.
`ifndef ADCDT_CFG_SVH
`define ADCDT_CFG_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ADCDT_MUXSEL_ADDR 8'hd0
`define ADCDT_DIAG_ADDR 8'hd1
`define ADCDT_BIAS_ADDR 8'hd2
`define ADCDT_THRESH0_ADDR 8'h60
`define ADCDT_THRESH1_ADDR 8'h61
`define ADCDT_THRESH2_ADDR 8'h62
`define ADCDT_THRESH3_ADDR 8'h63

// ****************************************************************
// Field positions
// ****************************************************************
`define ADCDT_VOLT_TEMP_INPUT_SELECT_LSB 0
`define ADCDT_VOLT_TEMP_INPUT_SELECT_MSB 2
`define ADCDT_SHUNT_INPUT_SELECT_LSB 3
`define ADCDT_SHUNT_INPUT_SELECT_MSB 5
`define ADCDT_MUXSEL_USED_MSB 5
`define ADCDT_DIAG_SELFTEST_BIT 0
`define ADCDT_DIAG_RAW_BIT 1
`define ADCDT_DIAG_IFTEST_BIT 2
`define ADCDT_PATTERN_BITS 30

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define ADCDT_MUXSEL_RESET 8'h00
`define ADCDT_DIAG_RESET 8'h80
`define ADCDT_BIAS_RESET 8'h00
`define ADCDT_THRESH_RESET 32'h0000_0000
`define ADCDT_DIRECT_MODE 3'h7
`define ADCDT_STO_FRAME_LEN 6

`endif

/* File: adcdt_pkg.sv */
// Types shared by the ADC test and diagnosis logic.
`default_nettype none
package adcdt_pkg;

  // Analog node that a multiplexer input can be switched to.
  typedef enum logic [3:0] {
    ND_VDDA = 4'h0, ND_THERM_HI = 4'h1, ND_THERM_LO = 4'h2,
    ND_PTAT = 4'h3, ND_VREF = 4'h4, ND_VBATP = 4'h5, ND_VBATN = 4'h6,
    ND_GND = 4'h7, ND_VREFLP = 4'h8, ND_VCM = 4'h9, ND_HIZ = 4'ha,
    ND_SHUNTP = 4'hb, ND_SHUNTN = 4'hc, ND_MV1 = 4'hd
  } adcdt_node_e;

  // Differential pair routed to one converter.
  typedef struct packed {
    adcdt_node_e pos;
    adcdt_node_e neg;
  } adcdt_pair_s;

  // One 32-bit decimation filter output split into two halves.
  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } adcdt_raw_s;

  // Serial test output frame position.
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_PRE1 = 7'h02, ST_PRE0 = 7'h04, ST_D3 = 7'h08,
    ST_D2 = 7'h10, ST_D1 = 7'h20, ST_D0 = 7'h40
  } adcdt_sto_e;

endpackage : adcdt_pkg
`default_nettype wire

/* File: adcdt_sto_shifter.sv */
// Serial shifter that frames sampled modulator bits onto the test pad.
`timescale 1ns/1ps
`default_nettype none
`include "adcdt_cfg.svh"
module adcdt_sto_shifter
  import adcdt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Sample side
  input wire logic enable,
  input wire logic sampleStrobe,
  input wire logic [3:0] sampleBits,
  // Pad side
  output logic stoBit
);

  adcdt_sto_e stateReg, stateNext;
  logic [3:0] pendReg, pendNext;
  logic [3:0] frameReg, frameNext;
  logic outReg, outNext;

  // ****************************************************************
  // Frame sequencer
  // ****************************************************************
  always_comb begin
    pendNext = sampleStrobe ? sampleBits : pendReg;
    frameNext = frameReg;
    stateNext = stateReg;
    unique case (stateReg)
      ST_IDLE: if (enable) stateNext = ST_PRE1;
      ST_PRE1: stateNext = ST_PRE0;
      ST_PRE0: stateNext = ST_D3;
      ST_D3: stateNext = ST_D2;
      ST_D2: stateNext = ST_D1;
      ST_D1: stateNext = ST_D0;
      ST_D0: stateNext = enable ? ST_PRE1 : ST_IDLE;
      default: stateNext = ST_IDLE;
    endcase
    // The newest sample is taken as the preamble starts.
    if (stateNext == ST_PRE1) begin
      frameNext = pendNext;
    end
    unique case (stateNext)
      ST_PRE1: outNext = 1'b1;
      ST_PRE0: outNext = 1'b0;
      ST_D3: outNext = frameNext[3];
      ST_D2: outNext = frameNext[2];
      ST_D1: outNext = frameNext[1];
      ST_D0: outNext = frameNext[0];
      default: outNext = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stateReg <= ST_IDLE;
      pendReg <= 4'h0;
      frameReg <= 4'h0;
      outReg <= 1'b0;
    end else begin
      stateReg <= stateNext;
      pendReg <= pendNext;
      frameReg <= frameNext;
      outReg <= outNext;
    end
  end

  assign stoBit = outReg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence preambleSeq;
    stoBit ##1 !stoBit;
  endsequence

  sequence payloadSeq(logic [3:0] v);
    stoBit == v[3] ##1 stoBit == v[2] ##1 stoBit == v[1]
      ##1 stoBit == v[0];
  endsequence

  sto_frame_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    stateNext == ST_PRE1 |=> preambleSeq ##1 payloadSeq($past(frameNext)))
    else $error("Test pad frame is not preamble then value.");

  sto_nogap_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (stateReg == ST_D0 && enable) |=> stateReg == ST_PRE1)
    else $error("Gap between test pad frames.");

endmodule : adcdt_sto_shifter
`default_nettype wire

/* File: adcdt_analog_model.sv */
// Behavioural model of the analog modulators and the converter strobe.
`timescale 1ns/1ps
`default_nettype none
module adcdt_analog_model
  import adcdt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control from the bench
  input wire logic run,
  input wire logic [3:0] streamValue,
  // Converter side
  output logic sdmStrobe,
  output logic [3:0] modulatorBits,
  output logic noiseCur,
  output var logic noiseVolt
);
  logic [2:0] divReg;

  // A strobe on every fifth clock gives a 10MHz sample rate from the 50MHz bench clock.
  // Outside a run the modulator lines churn so stale values never pass.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      divReg <= 3'h0;
      sdmStrobe <= 1'h0;
      modulatorBits <= 4'h0;
      noiseCur <= 1'h0;
    end else begin
      divReg <= (divReg == 3'h4) ? 3'h0 : divReg + 3'h1;
      sdmStrobe <= run && (divReg == 3'h4);
      modulatorBits <= run ? streamValue : ~modulatorBits;
      noiseCur <= ~noiseCur;
    end
  end

  always_comb noiseVolt = ~noiseCur;
endmodule : adcdt_analog_model
`default_nettype wire

/* File: test_adc_diag_test_logic.sv */
// Self-checking testbench of the ADC test and diagnosis logic.
`timescale 1ns/1ps
`default_nettype none
module test_adc_diag_test_logic
  import adcdt_pkg::*;
;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  localparam adcdt_pair_s VT_MAP[8] = '{'{ND_VDDA, ND_THERM_HI},
    '{ND_THERM_LO, ND_THERM_HI}, '{ND_PTAT, ND_VREF}, '{ND_VBATP, ND_VBATN},
    '{ND_VREF, ND_GND}, '{ND_VREFLP, ND_GND}, '{ND_VCM, ND_VCM},
    '{ND_HIZ, ND_HIZ}};
  localparam adcdt_pair_s CUR_MAP[8] = '{'{ND_SHUNTP, ND_SHUNTN},
    '{ND_SHUNTP, ND_SHUNTN}, '{ND_SHUNTP, ND_SHUNTN}, '{ND_SHUNTP, ND_SHUNTN},
    '{ND_MV1, ND_GND}, '{ND_HIZ, ND_HIZ}, '{ND_HIZ, ND_HIZ}, '{ND_VCM, ND_VCM}};
  logic clk, arst_n, regWrEn, regRdEn, fullPower, refSourceSel;
  logic [7:0] regAddr, regWrData, regRdData, biasSourceEnables;
  logic [2:0] conversionMode, modeVtSel, modeCurSel, pmuVtSel, pmuCurSel;
  adcdt_pair_s vtPair, curPair;
  adcdt_raw_s shuntCapture, voltCapture;
  logic refApplied, refSourceOut, sdmStrobe, noiseCancelCur, noiseCancelVolt;
  logic decimInCur, decimInVolt, accumThreshAvail, decimCurValid;
  logic decimVoltValid, shuntCaptureWr, voltCaptureWr, minMaxTrackEn;
  logic [31:0] decimCurOut, decimVoltOut;
  logic [3:0] modulatorBits, streamValue;
  logic serialTestOut, run;
  int fails = 0;
  int checksDone = 0;
  int cycles = 0;

  adcdt_diag_top adcdt_diag_top_inst (.clk, .arst_n, .regWrEn, .regRdEn,
    .regAddr, .regWrData, .regRdData, .fullPower, .conversionMode,
    .modeVtSel, .modeCurSel, .pmuVtSel, .pmuCurSel, .refSourceSel, .vtPair,
    .curPair, .refApplied, .refSourceOut, .biasSourceEnables, .sdmStrobe,
    .noiseCancelCur, .noiseCancelVolt, .decimInCur, .decimInVolt,
    .accumThreshAvail, .decimCurValid, .decimCurOut, .decimVoltValid,
    .decimVoltOut, .shuntCapture, .voltCapture, .shuntCaptureWr,
    .voltCaptureWr, .minMaxTrackEn, .modulatorBits, .serialTestOut);

  adcdt_analog_model adcdt_analog_model_inst (.clk, .arst_n, .run,
    .streamValue, .sdmStrobe, .modulatorBits, .noiseCur(noiseCancelCur),
    .noiseVolt(noiseCancelVolt));

  always #10 clk = ~clk;

  // ****************************************************************
  // Reporting and comparison
  // ****************************************************************
  task automatic complete_run;
    if (fails == 0 && checksDone > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  task automatic miss(input string msg);
    fails++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask : miss

  task automatic cmp_bit(input logic got, input logic exp, input string m);
    checksDone++;
    if (got !== exp) miss(m);
  endtask : cmp_bit

  task automatic cmp_byte(input logic [7:0] got, exp, input string m);
    checksDone++;
    if (got !== exp) miss(m);
  endtask : cmp_byte

  task automatic cmp_pair(input adcdt_pair_s got, exp, input string m);
    checksDone++;
    if (got !== exp) miss(m);
  endtask : cmp_pair

  task automatic cmp_raw(input adcdt_raw_s got, exp, input string m);
    checksDone++;
    if (got !== exp) miss(m);
  endtask : cmp_raw

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miss("run timed out");
      complete_run();
    end
  end

  // ****************************************************************
  // Bus and stimulus helpers
  // ****************************************************************
  task automatic reg_write(input logic [7:0] a, d);
    @(negedge clk);
    regWrEn = 1'h1;
    regAddr = a;
    regWrData = d;
    @(negedge clk);
    regWrEn = 1'h0;
  endtask : reg_write

  task automatic check_read(input logic [7:0] a, exp);
    @(negedge clk);
    regRdEn = 1'h1;
    regAddr = a;
    @(negedge clk);
    regRdEn = 1'h0;
    cmp_byte(regRdData, exp, "register read");
  endtask : check_read

  task automatic drive_raw(input logic v, input logic [31:0] c, w);
    @(negedge clk);
    decimCurValid = v;
    decimVoltValid = v;
    decimCurOut = c;
    decimVoltOut = w;
  endtask : drive_raw

  task automatic check_raw(input logic [31:0] c, w, input logic wr);
    cmp_bit(shuntCaptureWr, wr, "shunt capture strobe");
    cmp_bit(voltCaptureWr, wr, "volt capture strobe");
    cmp_raw(shuntCapture, c, "shunt capture word");
    cmp_raw(voltCapture, w, "volt capture word");
  endtask : check_raw

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset_values;
    check_read(8'hd0, 8'h00);
    check_read(8'hd1, 8'h80);
    check_read(8'hd2, 8'h00);
    for (int k = 0; k < 4; k++) begin
      check_read(8'h60 + k[7:0], 8'h00);
    end
    check_read(8'h55, 8'h00);
  endtask : test_reset_values

  task automatic test_direct_mux;
    for (int i = 0; i < 8; i++) begin
      refSourceSel = i[2:0] != 3'h4;
      reg_write(8'hd0, {2'h0, i[2:0], i[2:0]});
      repeat (2) @(negedge clk);
      cmp_pair(vtPair, VT_MAP[i], "volt pair");
      if (i < 5 || i == 7) cmp_pair(curPair, CUR_MAP[i], "cur pair");
      cmp_bit(refApplied, i == 2 || i == 4, "reference routed");
      if (i == 2 || i == 4)
        cmp_bit(refSourceOut, i == 2, "reference source");
    end
    check_read(8'hd0, 8'h3f);
  endtask : test_direct_mux

  task automatic test_mux_ignored;
    conversionMode = 3'h3;
    modeVtSel = 3'h1;
    modeCurSel = 3'h4;
    repeat (2) @(negedge clk);
    cmp_pair(vtPair, VT_MAP[1], "mode volt pair");
    cmp_pair(curPair, CUR_MAP[4], "mode cur pair");
    fullPower = 1'h0;
    conversionMode = 3'h7;
    pmuVtSel = 3'h3;
    repeat (2) @(negedge clk);
    cmp_pair(vtPair, VT_MAP[3], "manager volt pair");
    cmp_pair(curPair, CUR_MAP[0], "manager cur pair");
    fullPower = 1'h1;
    conversionMode = 3'h3;
    reg_write(8'hd2, 8'h51);
    repeat (2) @(negedge clk);
    cmp_byte(biasSourceEnables, 8'h51, "bias enables");
    check_read(8'hd2, 8'h51);
  endtask : test_mux_ignored

  task automatic test_selftest;
    logic [31:0] pat;
    logic [29:0] ring;
    pat = 32'h20820820;
    for (int k = 0; k < 4; k++) reg_write(8'h60 + k[7:0], pat[8*k+:8]);
    reg_write(8'hd1, 8'h81);
    ring = pat[29:0];
    cmp_bit(accumThreshAvail, 1'h0, "threshold blocked");
    repeat (60) begin
      cmp_bit(decimInCur, ring[0], "cur stream bit");
      cmp_bit(decimInVolt, ring[0], "volt stream bit");
      if (sdmStrobe) ring = {ring[0], ring[29:1]};
      @(negedge clk);
    end
    reg_write(8'hd1, 8'h80);
    cmp_bit(decimInCur, noiseCancelCur, "cur normal input");
    cmp_bit(accumThreshAvail, 1'h1, "threshold back");
  endtask : test_selftest

  task automatic test_raw;
    reg_write(8'hd1, 8'h83);
    drive_raw(1'h1, 32'h1234abcd, 32'hfedc0123);
    drive_raw(1'h1, 32'h0f0f5aa5, 32'h80000001);
    check_raw(32'h1234abcd, 32'hfedc0123, 1'h1);
    drive_raw(1'h0, 32'h0, 32'h0);
    check_raw(32'h0f0f5aa5, 32'h80000001, 1'h1);
    cmp_bit(minMaxTrackEn, 1'h0, "tracking off");
    reg_write(8'hd1, 8'h80);
    drive_raw(1'h1, 32'h55555555, 32'h5555aaaa);
    drive_raw(1'h0, 32'h0, 32'h0);
    check_raw(32'h0f0f5aa5, 32'h80000001, 1'h0);
    cmp_bit(minMaxTrackEn, 1'h1, "tracking on");
  endtask : test_raw

  task automatic test_serial;
    logic [5:0] frame;
    int n;
    frame = {2'h2, 4'hd};
    cmp_bit(serialTestOut, 1'h0, "pad idle");
    reg_write(8'hd1, 8'h84);
    n = 0;
    while (serialTestOut !== 1'h1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    cmp_bit(serialTestOut, 1'h1, "preamble start");
    repeat (6) @(negedge clk);
    for (int k = 0; k < 18; k++) begin
      cmp_bit(serialTestOut, frame[5 - k % 6], "serial bit");
      @(negedge clk);
    end
    fullPower = 1'h0;
    repeat (7) @(negedge clk);
    repeat (12) begin
      cmp_bit(serialTestOut, 1'h0, "pad quiet");
      @(negedge clk);
    end
  endtask : test_serial

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    clk = 1'h0;
    arst_n = 1'h0;
    regWrEn = 1'h0;
    regRdEn = 1'h0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    fullPower = 1'h1;
    conversionMode = 3'h7;
    modeVtSel = 3'h0;
    modeCurSel = 3'h0;
    pmuVtSel = 3'h0;
    pmuCurSel = 3'h0;
    refSourceSel = 1'h1;
    decimCurValid = 1'h0;
    decimVoltValid = 1'h0;
    decimCurOut = 32'h0;
    decimVoltOut = 32'h0;
    run = 1'h1;
    streamValue = 4'hd;
    repeat (4) @(negedge clk);
    arst_n = 1'h1;
    test_reset_values();
    test_direct_mux();
    test_mux_ignored();
    test_selftest();
    test_raw();
    test_serial();
    complete_run();
  end
endmodule : test_adc_diag_test_logic
`default_nettype wire
